/* logic/mos_map.svh */
// register offsets, field positions, reset values of the operation sequencer
// assumes a 10-bit byte address from a classic wishbone slave port
`ifndef MOS_MAP_SVH
`define MOS_MAP_SVH
`define MOS_CTRL 10'h000
`define MOS_VS 10'h004
`define MOS_SHARED 10'h008
`define MOS_JOG 10'h00c
`define MOS_JOG_TRAVEL 10'h010
`define MOS_HOME_OFS 10'h014
`define MOS_HOME_SPD 10'h018
`define MOS_DMAP_LO 10'h020
`define MOS_DMAP_HI 10'h024
`define MOS_STATUS 10'h028
`define MOS_TBL_SPD 2'b01
`define MOS_TBL_ACC 2'b10
`define MOS_B_ACC_COMMON 0
`define MOS_B_STOP_NOW 1
`define MOS_B_HOME_2S 2
`define MOS_B_HOME_DIR 3
`define MOS_B_SEQ_EN 18
`define MOS_CTRL_RST 4'h0
`define MOS_CUR_NONE 7'h7f
`define MOS_LAST_ENTRY 7'h3f
`define MOS_LINK_LAST 7'h3e
`define MOS_DMAP_W 6
`endif

/* logic/mos_pkg.sv */
// types of the operation sequencer
// constants live in mos_map.svh
package mos_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_POS = 6'h02, ST_CONT = 6'h04,
    ST_DECEL = 6'h08, ST_JOG = 6'h10, ST_HOME = 6'h20
  } mos_state_e;
  typedef enum logic [2:0] {
    K_POS = 3'h0, K_CONT = 3'h1, K_CONT_DEC = 3'h2, K_JOG = 3'h3, K_HOME = 3'h4
  } mos_kind_e;
  typedef enum logic [1:0] {
    M_SINGLE = 2'h0, M_LINK = 2'h1, M_LINK2 = 2'h2
  } mos_mode_e;
  typedef struct packed {
    logic cyc; logic stb; logic we; logic [3:0] sel;
    logic [9:0] adr; logic [31:0] dat;
  } mos_wb_req_s;
  typedef struct packed {
    logic start; logic seq_start; logic forward_run_input; logic reverse_run_input;
    logic jog_plus; logic jog_minus; logic home_start; logic origin_sensor;
    logic stop; logic excitation_off; logic alarm_reset; logic preset;
    logic configure; logic [5:0] direct_start;
  } mos_in_s;
  typedef struct packed {
    logic launch; logic halt; logic halt_now; mos_kind_e kind; logic dir;
    logic [5:0] entry; logic [15:0] speed; logic [15:0] rate; logic [31:0] travel;
  } mos_cmd_s;
endpackage : mos_pkg

/* logic/mos_sequencer.sv */
// operation sequencer: picks operation data entries and launches motion
// assumes a classic wishbone master and a datapath pulsing motion_done_i
`timescale 1ns/1ns
`include "mos_map.svh"
module mos_sequencer (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire mos_pkg::mos_wb_req_s wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire mos_pkg::mos_in_s io_i,
  input wire logic [5:0] data_select_i,
  input wire logic motion_done_i,
  output mos_pkg::mos_cmd_s cmd_o,
  output logic ref_capture_o,
  output logic chain_err_o,
  output logic [31:0] home_offset_o
);
  import mos_pkg::*;

  // register state
  logic [3:0] ctrl_ff;
  logic [15:0] vs_ff;
  logic [31:0] shared_ff;
  logic [31:0] jog_ff;
  logic [31:0] jog_travel_ff;
  logic [31:0] home_ofs_ff;
  logic [15:0] home_spd_ff;
  logic [5:0] dmap_ff [6];
  logic [15:0] spd_mem [64];
  logic [1:0] mode_mem [64];
  logic seqf_mem [64];
  logic [31:0] acc_mem [64];
  logic ack_ff;
  logic [31:0] rdat_ff;
  // sequencing state
  mos_state_e state_ff, nxt_state;
  logic [6:0] cur_ff, nxt_cur;
  logic [5:0] start_ff, nxt_start;
  logic [5:0] sel_ff, run_sel_ff;
  logic [15:0] run_spd_ff;
  logic dir_ff, nxt_dir;
  logic err_ff;
  mos_in_s in_ff, prev_ff;
  mos_cmd_s cmd_ff;
  logic ref_ff;

  // input stage and rising edges
  wire mos_in_s rise = in_ff & ~prev_ff;
  wire run_one = in_ff.forward_run_input ^ in_ff.reverse_run_input;
  wire run_same = dir_ff ? (in_ff.forward_run_input & ~in_ff.reverse_run_input) : (in_ff.reverse_run_input & ~in_ff.forward_run_input);
  wire moving = (state_ff != ST_IDLE);

  // bus decode
  wire wb_hit = wb_req_i.cyc & wb_req_i.stb & ~ack_ff;
  wire wb_wr = wb_hit & wb_req_i.we & ce_i;
  wire [1:0] tbl_sel = wb_req_i.adr[9:8];
  wire [5:0] tbl_idx = wb_req_i.adr[7:2];
  wire wr_spd = wb_wr & (tbl_sel == `MOS_TBL_SPD);
  wire wr_acc = wb_wr & (tbl_sel == `MOS_TBL_ACC);
  wire wr_reg = wb_wr & (tbl_sel == 2'b00);
  wire [31:0] wmask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
                       {8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
  wire [35:0] dmap_flat = {dmap_ff[5], dmap_ff[4], dmap_ff[3],
                           dmap_ff[2], dmap_ff[1], dmap_ff[0]};
  wire [31:0] status = {12'h0, err_ff, state_ff, start_ff, cur_ff};
  wire [31:0] spd_word = {13'h0, seqf_mem[tbl_idx], mode_mem[tbl_idx], spd_mem[tbl_idx]};
  logic [31:0] reg_rd;
  always_comb begin
    case (wb_req_i.adr)
      `MOS_CTRL: reg_rd = {28'h0, ctrl_ff};
      `MOS_VS: reg_rd = {16'h0, vs_ff};
      `MOS_SHARED: reg_rd = shared_ff;
      `MOS_JOG: reg_rd = jog_ff;
      `MOS_JOG_TRAVEL: reg_rd = jog_travel_ff;
      `MOS_HOME_OFS: reg_rd = home_ofs_ff;
      `MOS_HOME_SPD: reg_rd = {16'h0, home_spd_ff};
      `MOS_DMAP_LO: reg_rd = {8'h0, dmap_flat[23:0]};
      `MOS_DMAP_HI: reg_rd = {20'h0, dmap_flat[35:24]};
      `MOS_STATUS: reg_rd = status;
      default: reg_rd = 32'h0;
    endcase
  end
  wire [31:0] rd_mux = (tbl_sel == `MOS_TBL_SPD) ? spd_word :
                       (tbl_sel == `MOS_TBL_ACC) ? acc_mem[tbl_idx] :
                       (tbl_sel == 2'b00) ? reg_rd : 32'h0;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge
  wire [31:0] wdat = wb_req_i.dat;
  wire [31:0] spd_new = merge(spd_word, wdat, wmask);

  // next-entry selection for sequencing
  wire [6:0] inc = cur_ff + 7'h01;
  wire seq_wrap = (cur_ff == `MOS_LAST_ENTRY) || !seqf_mem[inc[5:0]];
  wire [5:0] seq_ent = seq_wrap ? start_ff : inc[5:0];
  logic [5:0] d_ent;
  logic d_any;
  always_comb begin
    d_ent = 6'h0;
    d_any = 1'b0;
    for (int k = 5; k >= 0; k--) begin
      if (rise.direct_start[k]) begin
        d_ent = dmap_ff[k];
        d_any = 1'b1;
      end
    end
  end

  // launch entry and chain length check
  logic [5:0] ent;
  wire [3:0] lk;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_chain
      wire [6:0] ix = {1'b0, ent} + 7'(g);
      assign lk[g] = (ix <= `MOS_LINK_LAST) && (mode_mem[ix[5:0]] != M_SINGLE);
    end
  endgenerate
  wire chain_bad = &lk;

  // rate from speed span and the chosen divisor
  logic go, decel, seq_reset, halt, pos_go;
  mos_kind_e kind;
  wire [15:0] ent_spd = spd_mem[ent];
  wire [15:0] tgt = (kind == K_JOG) ? jog_ff[15:0] :
                    (kind == K_HOME) ? home_spd_ff :
                    (kind == K_CONT_DEC) ? run_spd_ff : ent_spd;
  wire [15:0] span = (tgt > vs_ff) ? (tgt - vs_ff) : 16'h0;
  wire [31:0] ent_acc = acc_mem[ent];
  wire common = ctrl_ff[`MOS_B_ACC_COMMON];
  wire [15:0] div = common ? (decel ? shared_ff[31:16] : shared_ff[15:0])
                           : (decel ? ent_acc[31:16] : ent_acc[15:0]);
  wire [15:0] ramp = (div == 16'h0) ? 16'h0 : (span / div);
  // separate-mode acceleration rate built apart from the divisor mux, for the rate check
  wire [15:0] sep_rate = ((ent_spd > vs_ff) && (ent_acc[15:0] != 16'h0)) ?
                         ((ent_spd - vs_ff) / ent_acc[15:0]) : 16'h0;
  wire home_2s = ctrl_ff[`MOS_B_HOME_2S];
  wire [15:0] rate = (kind == K_JOG) ? jog_ff[31:16] :
                     (kind == K_HOME && home_2s) ? 16'h0 : ramp;

  // state machine and sequence bookkeeping
  always_comb begin
    nxt_state = state_ff;
    nxt_cur = cur_ff;
    nxt_start = start_ff;
    nxt_dir = dir_ff;
    go = 1'b0;
    pos_go = 1'b0;
    kind = K_POS;
    ent = sel_ff;
    decel = 1'b0;
    halt = rise.stop | rise.excitation_off;
    seq_reset = rise.stop | rise.excitation_off | rise.alarm_reset
                | rise.preset | rise.configure;
    if (halt) begin
      nxt_state = ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (rise.start | d_any) begin
            ent = rise.start ? sel_ff : d_ent;
            pos_go = 1'b1;
            nxt_start = ent;
            nxt_cur = {1'b0, ent};
          end else if (rise.seq_start) begin
            ent = seq_ent;
            pos_go = 1'b1;
            nxt_cur = {1'b0, seq_ent};
          end else if (rise.home_start) begin
            kind = K_HOME;
            go = 1'b1;
            nxt_dir = ctrl_ff[`MOS_B_HOME_DIR];
            nxt_state = ST_HOME;
          end else if (rise.jog_plus ^ rise.jog_minus) begin
            kind = K_JOG;
            go = 1'b1;
            nxt_dir = rise.jog_plus;
            nxt_state = ST_JOG;
          end else if (run_one) begin
            kind = K_CONT;
            go = 1'b1;
            nxt_dir = in_ff.forward_run_input;
            nxt_state = ST_CONT;
          end
          if (pos_go && !chain_bad) begin
            go = 1'b1;
            nxt_state = ST_POS;
          end else if (pos_go) begin
            nxt_cur = cur_ff;
            nxt_start = start_ff;
          end
          if (go && kind != K_POS) seq_reset = 1'b1;
        end
        ST_CONT: begin
          kind = K_CONT;
          if (!run_same) begin
            kind = K_CONT_DEC;
            decel = 1'b1;
            go = 1'b1;
            nxt_state = ST_DECEL;
          end else if (sel_ff != run_sel_ff) begin
            decel = (ent_spd < run_spd_ff);
            go = 1'b1;
          end
        end
        ST_DECEL: begin
          kind = K_CONT;
          if (run_same) begin
            go = 1'b1;
            nxt_state = ST_CONT;
          end else if (motion_done_i) begin
            nxt_state = ST_IDLE;
          end
        end
        ST_POS, ST_JOG, ST_HOME: if (motion_done_i) nxt_state = ST_IDLE;
        default: nxt_state = ST_IDLE;
      endcase
    end
    if (seq_reset) begin
      nxt_start = 6'h0;
      nxt_cur = `MOS_CUR_NONE;
    end
  end

  wire mos_cmd_s nxt_cmd = '{launch: go, halt: halt & moving,
    halt_now: ctrl_ff[`MOS_B_STOP_NOW], kind: kind, dir: nxt_dir, entry: ent,
    speed: tgt, rate: rate, travel: jog_travel_ff};
  wire err_set = pos_go & chain_bad & ~halt;

  // software-written registers and bus answer
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `MOS_CTRL_RST;
      vs_ff <= 16'h0;
      shared_ff <= 32'h0;
      jog_ff <= 32'h0;
      jog_travel_ff <= 32'h0;
      home_ofs_ff <= 32'h0;
      home_spd_ff <= 16'h0;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end else if (ce_i) begin
      ack_ff <= wb_hit;
      rdat_ff <= rd_mux;
      if (wr_reg && wb_req_i.adr == `MOS_CTRL) ctrl_ff <= 4'(merge({28'h0, ctrl_ff}, wdat, wmask));
      if (wr_reg && wb_req_i.adr == `MOS_VS) vs_ff <= 16'(merge({16'h0, vs_ff}, wdat, wmask));
      if (wr_reg && wb_req_i.adr == `MOS_SHARED) shared_ff <= merge(shared_ff, wdat, wmask);
      if (wr_reg && wb_req_i.adr == `MOS_JOG) jog_ff <= merge(jog_ff, wdat, wmask);
      if (wr_reg && wb_req_i.adr == `MOS_JOG_TRAVEL) jog_travel_ff <= merge(jog_travel_ff, wdat, wmask);
      if (wr_reg && wb_req_i.adr == `MOS_HOME_OFS) home_ofs_ff <= merge(home_ofs_ff, wdat, wmask);
      if (wr_reg && wb_req_i.adr == `MOS_HOME_SPD) home_spd_ff <= 16'(merge({16'h0, home_spd_ff}, wdat, wmask));
    end
  end

  // operation data table, not reset
  always_ff @(posedge sys_clk_i) begin
    if (ce_i && wr_spd) begin
      spd_mem[tbl_idx] <= spd_new[15:0];
      mode_mem[tbl_idx] <= spd_new[17:16];
      seqf_mem[tbl_idx] <= spd_new[`MOS_B_SEQ_EN];
    end
    if (ce_i && wr_acc) acc_mem[tbl_idx] <= merge(acc_mem[tbl_idx], wdat, wmask);
  end

  // direct start map, one field per input
  generate
    for (g = 0; g < 6; g++) begin : g_dmap
      localparam int B = g * `MOS_DMAP_W;
      wire [9:0] a = (B < 24) ? `MOS_DMAP_LO : `MOS_DMAP_HI;
      localparam int P = B % 24;
      wire [5:0] nw = wdat[P +: 6];
      wire we = wr_reg && (wb_req_i.adr == a) && wb_req_i.sel[P / 8] && wb_req_i.sel[(P + 5) / 8];
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) dmap_ff[g] <= 6'h0;
        else if (ce_i && we) dmap_ff[g] <= nw;
      end
    end
  endgenerate

  // input stage, sequence state, command out
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      in_ff <= '0;
      prev_ff <= '0;
      sel_ff <= 6'h0;
      state_ff <= ST_IDLE;
      cur_ff <= `MOS_CUR_NONE;
      start_ff <= 6'h0;
      dir_ff <= 1'b0;
      run_sel_ff <= 6'h0;
      run_spd_ff <= 16'h0;
      err_ff <= 1'b0;
      cmd_ff <= '0;
      ref_ff <= 1'b0;
    end else if (ce_i) begin
      in_ff <= io_i;
      prev_ff <= in_ff;
      sel_ff <= data_select_i;
      state_ff <= nxt_state;
      cur_ff <= nxt_cur;
      start_ff <= nxt_start;
      dir_ff <= nxt_dir;
      // command fields stand until the next launch; launch and halt pulse, halt_now follows ctrl_ff every cycle
      if (go) begin
        cmd_ff <= nxt_cmd;
      end else begin
        cmd_ff.launch <= 1'b0;
        cmd_ff.halt <= halt & moving;
        cmd_ff.halt_now <= ctrl_ff[`MOS_B_STOP_NOW];
      end
      ref_ff <= (state_ff == ST_HOME) & ~home_2s & rise.origin_sensor;
      if (go && (kind == K_CONT || kind == K_CONT_DEC)) begin
        run_sel_ff <= ent;
        run_spd_ff <= (kind == K_CONT) ? ent_spd : run_spd_ff;
      end
      if (err_set) err_ff <= 1'b1;
      else if (rise.alarm_reset) err_ff <= 1'b0;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign cmd_o = cmd_ff;
  assign ref_capture_o = ref_ff;
  assign chain_err_o = err_ff;
  assign home_offset_o = home_ofs_ff;

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_seq_reset_vals: assert property (ce_i && seq_reset |=> cur_ff == 7'h7f && start_ff == 6'h0)
    else $error("sequence point not cleared");
  a_seq_next_entry: assert property (ce_i && state_ff == ST_IDLE && !halt && !rise.start && !d_any
    && rise.seq_start && !chain_bad |=> cmd_o.launch && cmd_o.entry == $past(seq_ent))
    else $error("seq start did not launch expected entry");
  a_seq_wrap_back: assert property (ce_i && state_ff == ST_IDLE && rise.seq_start && seq_wrap
    && !halt && !rise.start && !d_any && !chain_bad
    |=> cmd_o.launch && cmd_o.entry == $past(start_ff))
    else $error("sequence did not return to start");
  a_start_point: assert property (ce_i && state_ff == ST_IDLE && rise.start && !seq_reset
    && !chain_bad |=> start_ff == $past(sel_ff) && cur_ff == {1'b0, $past(sel_ff)})
    else $error("start point not taken");
  a_stop_halts: assert property (ce_i && rise.stop && moving |=> cmd_o.halt && state_ff == ST_IDLE)
    else $error("stop did not halt motion");
  a_both_run_decel: assert property (ce_i && state_ff == ST_CONT && in_ff.forward_run_input && in_ff.reverse_run_input && !halt
    |=> state_ff == ST_DECEL && cmd_o.kind == K_CONT_DEC)
    else $error("both run inputs did not decelerate");
  a_chain_error: assert property (ce_i && err_set |=> chain_err_o && !cmd_o.launch)
    else $error("over-long chain launched");
  a_rate_value: assert property (ce_i && go && kind == K_POS && !common
    |=> cmd_o.rate == $past(sep_rate))
    else $error("rate mismatch");
  a_two_sensor_flat: assert property (ce_i && go && kind == K_HOME && home_2s |=> cmd_o.rate == 16'h0)
    else $error("two-sensor search ramped");
  c_seq_wrap: cover property (rise.seq_start && seq_wrap && state_ff == ST_IDLE);
  c_cont_resume: cover property (state_ff == ST_DECEL ##1 state_ff == ST_CONT);
  c_direct: cover property (d_any && state_ff == ST_IDLE);
  c_chain_err: cover property (err_set);
endmodule : mos_sequencer

/* dv/mos_motion_model.sv */
// stand-in for the motion datapath behind the sequencer's command port
// assumes cmd_o of the sequencer, one clock, synchronous active-high reset
`timescale 1ns/1ns
module mos_motion_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire mos_pkg::mos_cmd_s cmd_i,
  output logic motion_done_o
);
  import mos_pkg::*;
  logic [6:0] left_ff;
  // a run never ends by itself; moves end after a short or long delay
  always_ff @(posedge sys_clk_i) begin
    motion_done_o <= 1'b0;
    if (rst_i) begin
      left_ff <= 7'h00;
    end else if (cmd_i.launch) begin
      left_ff <= (cmd_i.kind == K_CONT) ? 7'h00 : (slow_i ? 7'h3c : 7'h03);
    end else if (cmd_i.halt) begin
      left_ff <= 7'h02; // halted motion settles quickly
    end else if (left_ff != 7'h00) begin
      left_ff <= left_ff - 7'h01;
      motion_done_o <= (left_ff == 7'h01);
    end
  end
endmodule : mos_motion_model

/* dv/testbench.sv */
// self-checking bench of the operation sequencer
// drives wishbone and the discrete inputs; a motion model closes the loop
`timescale 1ns/1ns
`include "mos_map.svh"
module testbench;
  import mos_pkg::*;
  localparam int B_ST = 18, B_SEQ = 17, B_FWD = 16, B_RVS = 15, B_JP = 14, B_JM = 13;
  localparam int B_HOME = 12, B_ORG = 11, B_STOP = 10, B_ARST = 8;
  logic sys_clk_i, rst_i, slow, done, wb_ack, ref_cap, chain_err, hit;
  logic [18:0] io_v;
  logic [5:0] sel_v;
  logic [31:0] wb_dat, home_ofs, rd;
  mos_wb_req_s wb;
  mos_cmd_s cmd;
  int n_fail = 0;
  int samples_checked = 0;

  mos_sequencer i_mos_sequencer (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_req_i(wb), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .io_i(io_v), .data_select_i(sel_v),
    .motion_done_i(done), .cmd_o(cmd), .ref_capture_o(ref_cap), .chain_err_o(chain_err),
    .home_offset_o(home_ofs));
  mos_motion_model i_mos_motion_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .slow_i(slow),
    .cmd_i(cmd), .motion_done_o(done));

  // 250 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    samples_checked++;
    if (got !== x) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, x, got);
    end
  endtask : chk

  // one classic cycle; request held until ack is seen, released after
  task automatic xfer(input logic we, input logic [9:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk_i);
      if (wb_ack === 1'b1) break;
    end
    if (i == 20) begin
      n_fail++;
      $display("[FAIL] wb ack expected 1 seen none");
      final_report();
    end
    rd = wb_dat;
    wb <= '0;
  endtask : xfer

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string nm, input logic [9:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk(nm, x, rd);
  endtask : rdc

  task automatic lvl(input int b, input logic v);
    @(posedge sys_clk_i);
    io_v[b] <= v;
  endtask : lvl

  task automatic setsel(input logic [5:0] v);
    @(posedge sys_clk_i);
    sel_v <= v;
  endtask : setsel

  // which: 0 launch, 1 halt, 2 reference capture
  task automatic await(input int which, input logic must, output logic h);
    h = 1'b0;
    repeat (30) begin
      @(negedge sys_clk_i);
      if ((which == 0 ? cmd.launch : which == 1 ? cmd.halt : ref_cap) === 1'b1) begin
        h = 1'b1;
        break;
      end
    end
    if (must && !h) begin
      n_fail++;
      $display("[FAIL] pulse %0d expected 1 seen none", which);
      final_report();
    end
  endtask : await

  // opt bit0 keeps the input on, bit1 skips entry and speed
  task automatic go(input int b, input mos_kind_e k, input logic [5:0] e,
                    input logic [15:0] s, input int opt);
    repeat (8) @(posedge sys_clk_i);
    io_v[b] <= 1'b1;
    await(0, 1'b1, hit);
    chk("kind", 32'(k), 32'(cmd.kind));
    if (opt[1] == 1'b0) begin
      chk("entry", 32'(e), 32'(cmd.entry));
      chk("speed", 32'(s), 32'(cmd.speed));
    end
    if (opt[0] == 1'b0) lvl(b, 1'b0);
  endtask : go

  function automatic logic [15:0] sp(input int n);
    return 16'(16'h0200 + n * 16);
  endfunction : sp

  // ramp rate with starting speed 0x100
  function automatic logic [31:0] rt(input logic [15:0] t, input logic [15:0] d);
    return (t <= 16'h0100 || d == 16'h0) ? 32'h0 : 32'((t - 16'h0100) / d);
  endfunction : rt

  initial begin
    int n;
    logic f;
    rst_i = 1'b1;
    slow = 1'b0;
    io_v = '0;
    sel_v = '0;
    wb = '0;
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rdc("ctrl", `MOS_CTRL, 32'h0);
    wr(10'h3fc, 32'hffff_ffff);
    rdc("unmapped", 10'h3fc, 32'h0);
    wr(`MOS_VS, 32'h0000_0100);
    rdc("vs", `MOS_VS, 32'h0000_0100);
    wr(`MOS_HOME_OFS, 32'h0000_0200);
    chk("home offset", 32'h0000_0200, home_ofs);
    for (n = 0; n < 14; n++) begin
      f = !(n == 2 || n == 6 || n == 12);
      wr(10'h100 + 10'(n * 4), {13'h0, f, (n >= 8 && n < 12) ? 2'b01 : 2'b00, sp(n)});
      wr(10'h200 + 10'(n * 4), 32'h0008_0004);
    end
    $display("test registers done");
    go(B_SEQ, K_POS, 6'd0, sp(0), 0);
    go(B_SEQ, K_POS, 6'd1, sp(1), 0);
    go(B_SEQ, K_POS, 6'd0, sp(0), 0);
    setsel(6'd3);
    go(B_ST, K_POS, 6'd3, sp(3), 0);
    go(B_SEQ, K_POS, 6'd4, sp(4), 0);
    go(B_SEQ, K_POS, 6'd5, sp(5), 0);
    go(B_SEQ, K_POS, 6'd3, sp(3), 0);
    $display("test sequencing done");
    wr(`MOS_CTRL, 32'h2);
    slow <= 1'b1;
    go(B_ST, K_POS, 6'd3, sp(3), 0);
    lvl(B_STOP, 1'b1);
    await(1, 1'b1, hit);
    chk("halt_now", 32'h1, 32'(cmd.halt_now));
    lvl(B_STOP, 1'b0);
    slow <= 1'b0;
    go(B_SEQ, K_POS, 6'd0, sp(0), 0);
    wr(`MOS_DMAP_LO, 32'h0000_0140);
    go(1, K_POS, 6'd5, sp(5), 0);
    $display("test stop and direct done");
    wr(`MOS_CTRL, 32'h0);
    setsel(6'd1);
    go(B_FWD, K_CONT, 6'd1, sp(1), 1);
    chk("dir", 32'h1, 32'(cmd.dir));
    chk("rate", rt(sp(1), 16'h4), 32'(cmd.rate));
    setsel(6'd3);
    await(0, 1'b1, hit);
    chk("speed", 32'(sp(3)), 32'(cmd.speed));
    slow <= 1'b1;
    lvl(B_FWD, 1'b0);
    await(0, 1'b1, hit);
    chk("kind", 32'(K_CONT_DEC), 32'(cmd.kind));
    chk("rate", rt(sp(3), 16'h8), 32'(cmd.rate));
    lvl(B_FWD, 1'b1);
    await(0, 1'b1, hit);
    chk("kind", 32'(K_CONT), 32'(cmd.kind));
    lvl(B_RVS, 1'b1);
    slow <= 1'b0;
    await(0, 1'b1, hit);
    chk("kind", 32'(K_CONT_DEC), 32'(cmd.kind));
    @(posedge sys_clk_i);
    io_v[16:15] <= 2'b00;
    wr(`MOS_CTRL, 32'h1);
    wr(`MOS_SHARED, 32'h0010_0002);
    setsel(6'd2);
    go(B_RVS, K_CONT, 6'd2, sp(2), 1);
    chk("dir", 32'h0, 32'(cmd.dir));
    chk("rate", rt(sp(2), 16'h2), 32'(cmd.rate));
    lvl(B_RVS, 1'b0);
    await(0, 1'b1, hit);
    chk("rate", rt(sp(2), 16'h10), 32'(cmd.rate));
    $display("test continuous done");
    wr(`MOS_JOG, 32'h0033_0150);
    wr(`MOS_JOG_TRAVEL, 32'h0000_1234);
    go(B_JP, K_JOG, 6'd0, 16'h0150, 2);
    chk("jog", {16'h0033, 15'h0, 1'b1}, {cmd.rate, 15'h0, cmd.dir});
    chk("travel", 32'h0000_1234, cmd.travel);
    go(B_JM, K_JOG, 6'd0, 16'h0150, 2);
    chk("dir", 32'h0, 32'(cmd.dir));
    wr(`MOS_CTRL, 32'h8);
    slow <= 1'b1;
    go(B_HOME, K_HOME, 6'd0, 16'h0, 2);
    chk("dir", 32'h1, 32'(cmd.dir));
    lvl(B_ORG, 1'b1);
    await(2, 1'b1, hit);
    lvl(B_ORG, 1'b0);
    slow <= 1'b0;
    repeat (70) @(posedge sys_clk_i);
    wr(`MOS_CTRL, 32'h4);
    go(B_HOME, K_HOME, 6'd0, 16'h0, 2);
    chk("dir rate", 32'h0, {15'h0, cmd.dir, cmd.rate});
    go(B_SEQ, K_POS, 6'd0, sp(0), 0);
    $display("test jog and home done");
    setsel(6'd8);
    repeat (8) @(posedge sys_clk_i);
    io_v[B_ST] <= 1'b1;
    await(0, 1'b0, hit);
    lvl(B_ST, 1'b0);
    chk("launch", 32'h0, 32'(hit));
    chk("chain err", 32'h1, 32'(chain_err));
    lvl(B_ARST, 1'b1);
    repeat (4) @(posedge sys_clk_i);
    io_v[B_ARST] <= 1'b0;
    @(negedge sys_clk_i);
    chk("chain err", 32'h0, 32'(chain_err));
    $display("test chain error done");
    final_report();
  end
endmodule : testbench
